/* hdl/cdrlk_ctrl.sv */
// Rate, reference, lock, loss of signal and data path control
`timescale 1ns/1ps
module cdrlk_ctrl #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       rateSelect,
    input  wire logic       refSourceSelect,
    input  wire logic [1:0] refFreqSelect,
    input  wire logic       extRefClockIn,
    input  wire logic       crystalOscIn,
    input  wire logic       oscDivIn,
    input  wire logic       levelBelowThreshold,
    input  wire logic       squelch,
    input  wire logic       bypass,
    input  wire logic       loopbackEnable,
    input  wire logic       quantizerData,
    input  wire logic       testDataIn,
    input  wire logic       recClock,
    input  wire logic       recData,
    input  wire logic       inValid,
    output logic            inReady,
    output logic            outValid,
    input  wire logic       outReady,
    output logic            signalDetectOut,
    output logic            lockLost,
    output logic            phaseLoopActive,
    output logic            rateFec,
    output logic [15:0]     refDivWindow,
    output logic            cdrInput,
    output logic            clockOut,
    output logic            dataOut
);
    typedef enum logic {FREQ_LOOP, PHASE_LOOP} cdrlk_loop_e;
    // =============================================================
    // Three-stage synchronisers for pin inputs
    logic [2:0] sRate_q, sRsrc_q, sF0_q, sF1_q, sLvl_q, sSq_q, sByp_q;
    logic [2:0] sLpb_q, sRef_q, sXo_q, sOsc_q;
    logic [2:0] sRate_d, sRsrc_d, sF0_d, sF1_d, sLvl_d, sSq_d, sByp_d;
    logic [2:0] sLpb_d, sRef_d, sXo_d, sOsc_d;
    always_comb begin
        sRate_d = {sRate_q[1:0], rateSelect};
        sRsrc_d = {sRsrc_q[1:0], refSourceSelect};
        sF0_d   = {sF0_q[1:0], refFreqSelect[0]};
        sF1_d   = {sF1_q[1:0], refFreqSelect[1]};
        sLvl_d  = {sLvl_q[1:0], levelBelowThreshold};
        sSq_d   = {sSq_q[1:0], squelch};
        sByp_d  = {sByp_q[1:0], bypass};
        sLpb_d  = {sLpb_q[1:0], loopbackEnable};
        sRef_d  = {sRef_q[1:0], extRefClockIn};
        sXo_d   = {sXo_q[1:0], crystalOscIn};
        sOsc_d  = {sOsc_q[1:0], oscDivIn};
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sRate_q <= '0;
            sRsrc_q <= '0;
            sF0_q   <= '0;
            sF1_q   <= '0;
            sLvl_q  <= '0;
            sSq_q   <= '0;
            sByp_q  <= '0;
            sLpb_q  <= '0;
            sRef_q  <= '0;
            sXo_q   <= '0;
            sOsc_q  <= '0;
        end else begin
            sRate_q <= sRate_d;
            sRsrc_q <= sRsrc_d;
            sF0_q   <= sF0_d;
            sF1_q   <= sF1_d;
            sLvl_q  <= sLvl_d;
            sSq_q   <= sSq_d;
            sByp_q  <= sByp_d;
            sLpb_q  <= sLpb_d;
            sRef_q  <= sRef_d;
            sXo_q   <= sXo_d;
            sOsc_q  <= sOsc_d;
        end
    end
    // =============================================================
    // Filtered levels: change once stages two and three agree
    logic rate_q, rsrc_q, byp_q, lpb_q, sq_q, lvl_q;
    logic [1:0] fsel_q;
    logic rate_d, rsrc_d, byp_d, lpb_d, sq_d;
    logic [1:0] fsel_d;
    always_comb begin
        rate_d = (sRate_q[2] == sRate_q[1]) ? sRate_q[2] : rate_q;
        rsrc_d = (sRsrc_q[2] == sRsrc_q[1]) ? sRsrc_q[2] : rsrc_q;
        byp_d  = (sByp_q[2] == sByp_q[1]) ? sByp_q[2] : byp_q;
        lpb_d  = (sLpb_q[2] == sLpb_q[1]) ? sLpb_q[2] : lpb_q;
        sq_d   = (sSq_q[2] == sSq_q[1]) ? sSq_q[2] : sq_q;
        fsel_d[0] = (sF0_q[2] == sF0_q[1]) ? sF0_q[2] : fsel_q[0];
        fsel_d[1] = (sF1_q[2] == sF1_q[1]) ? sF1_q[2] : fsel_q[1];
    end
    // =============================================================
    // Reference selection and window length
    logic        refEdge, oscEdge;
    logic [15:0] win;
    always_comb begin
        // Crystal is 19.44 MHz; external select ignored when low
        if (!rsrc_q) begin
            refEdge = sXo_q[1] && !sXo_q[2];
            win     = cdrlk_pkg::WIN_19M;
        end else begin
            refEdge = sRef_q[1] && !sRef_q[2];
            unique case (fsel_q)
                cdrlk_pkg::REF_19M:  win = cdrlk_pkg::WIN_19M;
                cdrlk_pkg::REF_38M:  win = cdrlk_pkg::WIN_38M;
                cdrlk_pkg::REF_77M:  win = cdrlk_pkg::WIN_77M;
                cdrlk_pkg::REF_155M: win = cdrlk_pkg::WIN_155M;
            endcase
        end
        oscEdge = sOsc_q[1] && !sOsc_q[2];
    end
    // =============================================================
    // Frequency error measurement and lock hysteresis
    logic [15:0] refCnt_q, refCnt_d;
    logic [23:0] oscCnt_q, oscCnt_d;
    cdrlk_loop_e loop_q, loop_d;
    logic [23:0] expected, err, tolLock, tolUnlock;
    always_comb begin
        // Same window for any rate; only expected count moves
        expected = rate_q ? cdrlk_pkg::EXP_FEC : cdrlk_pkg::EXP_NATIVE;
        tolLock  = 24'((64'(expected) * cdrlk_pkg::LOCK_PPM)
                   / cdrlk_pkg::PPM_SCALE);
        tolUnlock = 24'((64'(expected) * cdrlk_pkg::UNLOCK_PPM)
                    / cdrlk_pkg::PPM_SCALE);
        err = (oscCnt_q > expected) ? oscCnt_q - expected
                                     : expected - oscCnt_q;
        refCnt_d = refCnt_q;
        oscCnt_d = oscCnt_q + 24'(oscEdge);
        loop_d   = loop_q;
        // Window counts undivided reference edges; only the oscillator input is prescaled
        if (refEdge) begin
            if (refCnt_q >= win - 16'h0001) begin
                refCnt_d = '0;
                oscCnt_d = 24'(oscEdge);
                unique case (loop_q)
                    FREQ_LOOP:  if (err <= tolLock) loop_d = PHASE_LOOP;
                    PHASE_LOOP: if (err > tolUnlock) loop_d = FREQ_LOOP;
                endcase
            end else begin
                refCnt_d = refCnt_q + 16'h0001;
            end
        end
    end
    // =============================================================
    // Loss of signal delay
    logic [5:0] losCnt_q, losCnt_d;
    logic       lvl_d;
    always_comb begin
        losCnt_d = losCnt_q;
        lvl_d    = lvl_q;
        if (sLvl_q[2] != sLvl_q[1]) begin
            losCnt_d = '0;
        end else if (sLvl_q[2] == lvl_q) begin
            losCnt_d = '0;
        end else if (losCnt_q >= 6'(cdrlk_pkg::LOS_CYCLES
                                    - cdrlk_pkg::LOS_SYNC_CYCLES)) begin
            lvl_d    = sLvl_q[2];
            losCnt_d = '0;
        end else begin
            losCnt_d = losCnt_q + 6'h01;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {rate_q, rsrc_q, byp_q, lpb_q, sq_q, lvl_q} <= '0;
            fsel_q   <= '0;
            refCnt_q <= '0;
            oscCnt_q <= '0;
            loop_q   <= FREQ_LOOP;
            losCnt_q <= '0;
        end else begin
            {rate_q, rsrc_q, byp_q, lpb_q, sq_q, lvl_q} <=
                {rate_d, rsrc_d, byp_d, lpb_d, sq_d, lvl_d};
            fsel_q   <= fsel_d;
            refCnt_q <= refCnt_d;
            oscCnt_q <= oscCnt_d;
            loop_q   <= loop_d;
            losCnt_q <= losCnt_d;
        end
    end
    // =============================================================
    // Recovered stream through the FIFO
    logic [1:0] fifoOut;
    cdrlk_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clock    (clock),
        .rstn     (rstn),
        .inData   (WIDTH'({recClock, recData})),
        .inValid  (inValid),
        .inReady  (inReady),
        .outData  (fifoOut),
        .outValid (outValid),
        .outReady (outReady)
    );
    // =============================================================
    // Output registers
    logic clkOut_d, datOut_d, cdrIn_d;
    always_comb begin
        cdrIn_d  = lpb_q ? testDataIn : quantizerData;
        clkOut_d = fifoOut[1];
        datOut_d = byp_q ? quantizerData : fifoOut[0];
        if (sq_q) begin
            clkOut_d = 1'b0;
            datOut_d = 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cdrInput     <= 1'b0;
            clockOut     <= 1'b0;
            dataOut      <= 1'b0;
            refDivWindow <= cdrlk_pkg::WIN_19M;
        end else begin
            cdrInput     <= cdrIn_d;
            clockOut     <= clkOut_d;
            dataOut      <= datOut_d;
            refDivWindow <= win;
        end
    end
    // =============================================================
    // Status outputs
    assign signalDetectOut = lvl_q;
    assign lockLost        = loop_q == FREQ_LOOP;
    assign phaseLoopActive = loop_q == PHASE_LOOP;
    assign rateFec         = rate_q;
endmodule

/* hdl/cdrlk_fifo.sv */
// Small valid/ready FIFO for the recovered bit stream
`timescale 1ns/1ps
module cdrlk_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;
    // =============================================================
    // Pointer and storage update
    always_comb begin
        inReady  = cnt_q != (AW+1)'(DEPTH);
        outValid = cnt_q != '0;
        push     = inValid && inReady;
        pop      = outValid && outReady;
        mem_d    = mem_q;
        wr_d     = wr_q;
        rd_d     = rd_q;
        if (push) begin
            mem_d[wr_q] = inData;
            wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
    assign outData = mem_q[rd_q];
endmodule

/* inc/cdrlk_pkg.sv */
// Constants for the recovery mode and lock control block
// =============================================================
package cdrlk_pkg;
    // =============================================================
    // Timing
    localparam int  CLK_PERIOD_NS = 10;
    localparam int  LOS_TIME_NS   = 300;
    localparam int  LOS_CYCLES    = LOS_TIME_NS / CLK_PERIOD_NS;
    // Cycles already spent in the synchroniser before counting starts
    localparam int  LOS_SYNC_CYCLES = 4;
    // =============================================================
    // Lock thresholds in ppm
    localparam int  LOCK_PPM   = 500;
    localparam int  UNLOCK_PPM = 1000;
    localparam int  PPM_SCALE  = 1000000;
    // =============================================================
    // Reference window lengths in reference cycles, per frequency
    localparam logic [1:0] REF_19M = 2'h0;
    localparam logic [1:0] REF_38M = 2'h1;
    localparam logic [1:0] REF_77M = 2'h2;
    localparam logic [1:0] REF_155M = 2'h3;
    localparam logic [15:0] WIN_19M  = 16'h0800;
    localparam logic [15:0] WIN_38M  = 16'h1000;
    localparam logic [15:0] WIN_77M  = 16'h2000;
    localparam logic [15:0] WIN_155M = 16'h4000;
    // Oscillator prescale: undivided oscillator equals 19.44 MHz times this
    localparam int  OSC_DIV_RATIO = 128;
    // Expected divided counts per window, equal to the 19.44 MHz window for native rate
    localparam logic [23:0] EXP_NATIVE = 24'h000800;
    localparam logic [23:0] EXP_FEC    = 24'h000892;
    localparam logic RATE_NATIVE = 1'b0;
    localparam logic RATE_FEC    = 1'b1;
endpackage

/* sim/cdrlk_ctrl_asserts.sv */
// Port-level properties of the lock control block
`timescale 1ns/1ps
module cdrlk_ctrl_asserts (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        rateSelect,
    input wire logic        refSourceSelect,
    input wire logic [1:0]  refFreqSelect,
    input wire logic        levelBelowThreshold,
    input wire logic        squelch,
    input wire logic        bypass,
    input wire logic        quantizerData,
    input wire logic        loopbackEnable,
    input wire logic        testDataIn,
    input wire logic        inReady,
    input wire logic        signalDetectOut,
    input wire logic        lockLost,
    input wire logic        phaseLoopActive,
    input wire logic        rateFec,
    input wire logic [15:0] refDivWindow,
    input wire logic        cdrInput,
    input wire logic        clockOut,
    input wire logic        dataOut
);
    // ============================================================
    // Run length of the input level
    logic [5:0] run_q;
    logic [5:0] run_d;
    logic       lvl_q;
    always_comb begin
        run_d = (levelBelowThreshold != lvl_q) ? 6'h00 :
                (run_q == 6'h3f) ? run_q : run_q + 6'h01;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_q <= 6'h00;
            lvl_q <= 1'b0;
        end else begin
            run_q <= run_d;
            lvl_q <= levelBelowThreshold;
        end
    end
    // ============================================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_rate_follow: assert property ($stable(rateSelect) [*8] |->
        rateFec == rateSelect) else $error("rate select not followed");
    chk_ref_window: assert property (
        ($stable(refSourceSelect) && $stable(refFreqSelect)) [*8] |->
        refDivWindow == (16'h0800 << (refSourceSelect ? refFreqSelect
        : 2'h0))) else $error("reference window wrong");
    chk_loop_phase: assert property (phaseLoopActive == !lockLost)
        else $error("loop control disagrees with lock flag");
    chk_lock_hold: assert property (
        $changed(lockLost) |=> $stable(lockLost) [*8])
        else $error("lock flag changed inside a window");
    chk_los_level: assert property (run_q >= 6'h28 |->
        signalDetectOut == lvl_q) else $error("signal detect wrong");
    chk_los_delay: assert property (
        $rose(levelBelowThreshold) && !signalDetectOut |->
        !signalDetectOut [*8]) else $error("signal loss too early");
    chk_squelch_zero: assert property (squelch [*6] |->
        !clockOut && !dataOut) else $error("squelch left output high");
    chk_bypass_data: assert property (
        (bypass && !squelch && $stable(quantizerData)) [*8] |->
        dataOut == quantizerData) else $error("bypass data wrong");
    chk_loop_input: assert property (
        (loopbackEnable && $stable(testDataIn)) [*8] |->
        cdrInput == testDataIn) else $error("test data not selected");
    chk_main_input: assert property (
        (!loopbackEnable && $stable(quantizerData)) [*8] |->
        cdrInput == quantizerData) else $error("main data not selected");
    cover property ($fell(lockLost));
    cover property ($rose(signalDetectOut));
    cover property (!inReady);
endmodule
bind cdrlk_ctrl cdrlk_ctrl_asserts u_chk (
    .clock, .rstn, .rateSelect, .refSourceSelect, .refFreqSelect,
    .levelBelowThreshold, .squelch, .bypass, .quantizerData,
    .loopbackEnable, .testDataIn, .inReady, .signalDetectOut, .lockLost,
    .phaseLoopActive, .rateFec, .refDivWindow, .cdrInput, .clockOut,
    .dataOut
);

/* sim/cdrlk_ctrl_tb.sv */
// Self-checking bench for the lock control block
`timescale 1ns/1ps
module cdrlk_ctrl_tb;
    logic clock = 1'b0, rstn = 1'b0, rateSelect = 1'b0, refSourceSelect = 1'b1;
    logic [1:0] refFreqSelect = 2'h0;
    logic extRefClockIn = 1'b0, crystalOscIn = 1'b0, oscDivIn = 1'b0;
    logic squelch = 1'b0, bypass = 1'b0, loopbackEnable = 1'b0;
    logic testDataIn = 1'b0, recClock = 1'b0, recData = 1'b0;
    logic inValid = 1'b0, outReady = 1'b0, lightOn = 1'b1, stall = 1'b0;
    logic fast = 1'b0, quantizerData, levelBelowThreshold, inReady;
    logic outValid, signalDetectOut, lockLost, phaseLoopActive, rateFec;
    logic [15:0] refDivWindow;
    logic cdrInput, clockOut, dataOut;
    int miscompares = 0, nChecks = 0, cyc = 0, ph = 0;
    // ============================================================
    // Clock, reference pins and hang guard
    always #5 clock = ~clock;
    always @(posedge clock) begin
        #1;
        ph++;
        cyc++;
        extRefClockIn = ph[1];
        crystalOscIn = ph[1];
        oscDivIn = fast ? ph[0] : ph[1];
        if (cyc == 90000) begin
            miscompares++;
            tallyAndFinish();
        end
    end
    cdrlk_front_end u_fe (.clock, .lightOn, .stall, .quantizerData,
        .levelBelowThreshold);
    cdrlk_ctrl #(.WIDTH(2), .DEPTH(8)) dut (.clock, .rstn, .rateSelect,
        .refSourceSelect, .refFreqSelect, .extRefClockIn, .crystalOscIn,
        .oscDivIn, .levelBelowThreshold, .squelch, .bypass,
        .loopbackEnable, .quantizerData, .testDataIn, .recClock, .recData,
        .inValid, .inReady, .outValid, .outReady, .signalDetectOut,
        .lockLost, .phaseLoopActive, .rateFec, .refDivWindow, .cdrInput,
        .clockOut, .dataOut);
    // ============================================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    task automatic tModes();
        for (int k = 0; k < 8; k++) begin
            rateSelect = k[2];
            refFreqSelect = k[1:0];
            step(8);
            chk(16'(rateFec), 16'(k[2]));
            chk(refDivWindow, 16'h0800 << k[1:0]);
        end
        refSourceSelect = 1'b0;
        step(8);
        chk(refDivWindow, 16'h0800);
        {rateSelect, refSourceSelect, refFreqSelect} = 4'h4;
    endtask
    task automatic tPaths();
        stall = 1'b1;
        bypass = 1'b1;
        for (int k = 0; k < 3; k++) begin
            squelch = 1'b1;
            step(6);
            chk(16'({clockOut, dataOut}), 16'h0);
            squelch = 1'b0;
            step(8);
            chk(16'(dataOut), 16'(quantizerData));
            stall = 1'b0;
            step(1);
            stall = 1'b1;
        end
        bypass = 1'b0;
        loopbackEnable = 1'b1;
        for (int k = 0; k < 2; k++) begin
            testDataIn = k[0];
            step(8);
            chk(16'(cdrInput), 16'(k[0]));
        end
        loopbackEnable = 1'b0;
        step(8);
        chk(16'(cdrInput), 16'(quantizerData));
        stall = 1'b0;
    endtask
    task automatic tLos();
        lightOn = 1'b0;
        step(20);
        chk(16'(signalDetectOut), 16'h0);
        step(20);
        chk(16'(signalDetectOut), 16'h1);
        lightOn = 1'b1;
        step(40);
        chk(16'(signalDetectOut), 16'h0);
    endtask
    task automatic tFifo();
        int n;
        int pops;
        logic pop;
        n = 0;
        pops = 0;
        inValid = 1'b1;
        for (int k = 0; k < 12; k++) begin
            {recClock, recData} = 2'(n);
            #3;
            if (inReady)
                n++;
            step(1);
        end
        inValid = 1'b0;
        chk(16'(n), 16'h8);
        chk(16'(inReady), 16'h0);
        for (int k = 0; k < 24; k++) begin
            outReady = k[0];
            #3;
            pop = outValid && outReady;
            step(1);
            if (pop) begin
                chk(16'({clockOut, dataOut}), 16'(pops[1:0]));
                pops++;
            end
        end
        outReady = 1'b0;
        chk(16'(pops), 16'h8);
        chk(16'(outValid), 16'h0);
    endtask
    task automatic tLock(input logic v);
        for (int k = 0; k < 25000 && lockLost !== v; k++)
            step(1);
        chk(16'(lockLost), 16'(v));
        chk(16'(phaseLoopActive), 16'(!v));
    endtask
    initial begin
        repeat (12) @(posedge clock);
        #1;
        chk(16'(lockLost), 16'h1);
        chk(refDivWindow, 16'h0800);
        rstn = 1'b1;
        step(4);
        tModes();
        tPaths();
        tLos();
        tFifo();
        tLock(1'b0);
        fast = 1'b1;
        tLock(1'b1);
        fast = 1'b0;
        tLock(1'b0);
        tallyAndFinish();
    end
endmodule

/* sim/cdrlk_front_end.sv */
// Optical front end model: bit pattern and light level
`timescale 1ns/1ps
module cdrlk_front_end (
    input  wire logic clock,
    input  wire logic lightOn,
    input  wire logic stall,
    output logic      quantizerData,
    output logic      levelBelowThreshold
);
    logic [6:0] patt_q = 7'h5a;
    always @(posedge clock) begin
        if (!stall || !lightOn)
            patt_q <= {patt_q[5:0], patt_q[6] ^ patt_q[5]};
    end
    // Dark input shows noise, never a frozen level
    assign quantizerData       = lightOn ? patt_q[0] : ^patt_q;
    assign levelBelowThreshold = !lightOn;
endmodule
